/* File: sbc_pkg.sv */
// Constants, types and register layout for the serial bus control and status block.
package sbc_pkg;

    localparam logic [7:0] OFS_DATA = 8'hB0;
    localparam logic [7:0] OFS_INDEX = 8'hB1;
    localparam logic [7:0] OFS_TADDR = 8'hB2;
    localparam logic [7:0] OFS_CTRL = 8'hB3;

    localparam int BIT_SHORT = 7;
    localparam int BIT_RSVD = 6;
    localparam int BIT_REQ = 5;
    localparam int BIT_ROM = 4;
    localparam int BIT_PRESENT = 3;
    localparam int BIT_FAST = 2;
    localparam int BIT_REQERR = 1;
    localparam int BIT_ROMERR = 0;
    localparam int BIT_DIR = 0;

    localparam logic [7:0] RST_BYTE = 8'h00;

    localparam int BUS_CLK_KHZ = 100;
    localparam int LINK_CLK_NS = 48;
    localparam int QUARTER_NS = 1000000 / (BUS_CLK_KHZ * 4);
    localparam int QUARTER_CYC = (QUARTER_NS + LINK_CLK_NS - 1) / LINK_CLK_NS;
    localparam int FAST_QUARTER_CYC = 2;
    localparam logic [7:0] QUARTER_RELOAD = 8'(QUARTER_CYC - 1);
    localparam logic [7:0] FAST_RELOAD = 8'(FAST_QUARTER_CYC - 1);
    localparam logic [1:0] STRAP_WAIT = 2'h3;
    localparam logic [3:0] ACK_SLOT = 4'h8;

    typedef enum logic [1:0] {
        AU_STRAP = 2'b00,
        AU_LAUNCH = 2'b01,
        AU_WAIT = 2'b10,
        AU_DONE = 2'b11
    } sbc_auto_t;

    typedef enum logic [1:0] {
        OP_START = 2'b00,
        OP_WRITE = 2'b01,
        OP_READ = 2'b10,
        OP_STOP = 2'b11
    } sbc_op_t;

endpackage

/* File: sbc_ctrl.sv */
// Serial bus master with register port, EEPROM auto-load and a link-clock bit engine.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`default_nettype none

module sbc_ctrl
    import sbc_pkg::*;
#(
    parameter logic [6:0] EEPROM_ADDR = 7'h50,
    parameter logic [7:0] FORMAT_MARK = 8'h5A,
    parameter logic [1:0] AUTO_LAST = 2'h2
) (
    input wire logic I_CORE_CLK,
    input wire logic I_RST_B,
    input wire logic I_LINK_CLK,
    input wire logic [7:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [7:0] O_RDATA,
    input wire logic I_LATCH_STRAP,
    input wire logic I_SCL,
    output logic O_SCL_O,
    output logic O_SCL_OE,
    input wire logic I_SDA,
    output logic O_SDA_O,
    output logic O_SDA_OE,
    output logic [15:0] O_SUBSYS_ID,
    output logic O_SHARED_PINS_FREE
);

    typedef struct packed {
        logic [7:0] xfer_data;
        logic [7:0] byte_addr;
        logic [7:0] taddr;
        logic short_sel;
        logic fast_test;
        logic req_busy;
        logic rom_busy;
        logic present;
        logic pins_free;
        logic req_err;
        logic rom_err;
        logic pend;
        logic eng_busy;
        logic eng_auto;
        logic [6:0] snap_addr;
        logic snap_rd;
        logic [7:0] snap_idx;
        logic [7:0] snap_data;
        logic snap_short;
        logic req_tgl;
        logic done_s1;
        logic done_s2;
        logic done_s3;
        logic strap_s1;
        logic strap_s2;
        logic [1:0] strap_cnt;
        sbc_auto_t auto_st;
        logic [1:0] auto_idx;
        logic [15:0] subsys;
        logic [7:0] rdata;
    } sbc_core_t;

    typedef struct packed {
        logic req_s1;
        logic req_s2;
        logic req_s3;
        logic fast_s1;
        logic fast_s2;
        logic scl_s1;
        logic scl_s2;
        logic sda_s1;
        logic sda_s2;
        logic run;
        logic abort;
        logic err;
        logic [2:0] step;
        logic [3:0] bitn;
        logic [1:0] ph;
        logic [7:0] div;
        logic [7:0] shreg;
        logic [7:0] rd_byte;
        logic done_tgl;
        logic scl_oe;
        logic sda_oe;
        logic pin_o;
    } sbc_link_t;

    sbc_core_t c;
    sbc_core_t next_c;
    sbc_link_t l;
    sbc_link_t next_l;
    logic done_edge;
    logic tick;
    logic advance;
    sbc_op_t op;
    logic [7:0] cur_byte;
    logic [7:0] shv;

    // Frame layouts: long read START,A+W,IDX,START,A+R,READ,STOP; long write START,A+W,IDX,DATA,STOP.
    // Short read START,A+R,READ,STOP; short write START,A+W,DATA,STOP.
    function automatic sbc_op_t op_of(input logic [2:0] step, input logic rd, input logic sh);
        sbc_op_t r;
        r = OP_STOP;
        case (step)
            3'd0: r = OP_START;
            3'd1: r = OP_WRITE;
            3'd2: r = (sh && rd) ? OP_READ : OP_WRITE;
            3'd3: r = sh ? OP_STOP : (rd ? OP_START : OP_WRITE);
            3'd4: r = rd ? OP_WRITE : OP_STOP;
            3'd5: r = OP_READ;
            default: r = OP_STOP;
        endcase
        return r;
    endfunction

    function automatic logic [7:0] byte_of(input logic [2:0] step, input logic rd, input logic sh,
                                           input logic [6:0] a, input logic [7:0] idx, input logic [7:0] dat);
        logic [7:0] r;
        r = dat;
        case (step)
            3'd1: r = {a, rd & sh};
            3'd2: r = sh ? dat : idx;
            3'd4: r = {a, 1'b1};
            default: r = dat;
        endcase
        return r;
    endfunction

    assign done_edge = c.done_s2 != c.done_s3;

    always_comb begin
        next_c = c;
        next_c.done_s1 = l.done_tgl;
        next_c.done_s2 = c.done_s1;
        next_c.done_s3 = c.done_s2;
        next_c.strap_s1 = I_LATCH_STRAP;
        next_c.strap_s2 = c.strap_s1;
        next_c.rdata = RST_BYTE;
        if (I_RD) begin
            case (I_ADDR)
                OFS_DATA: next_c.rdata = c.xfer_data;
                OFS_INDEX: next_c.rdata = c.byte_addr;
                OFS_TADDR: next_c.rdata = c.taddr;
                OFS_CTRL: next_c.rdata = {c.short_sel, 1'b0, c.req_busy, c.rom_busy,
                                          c.present, c.fast_test, c.req_err, c.rom_err};
                default: next_c.rdata = RST_BYTE;
            endcase
        end
        if (I_WR) begin
            case (I_ADDR)
                OFS_DATA: next_c.xfer_data = I_WDATA;
                OFS_INDEX: next_c.byte_addr = I_WDATA;
                OFS_TADDR: begin
                    next_c.taddr = I_WDATA;
                    if (!c.req_busy) begin
                        next_c.req_busy = 1'b1;
                        next_c.pend = 1'b1;
                    end
                end
                OFS_CTRL: begin
                    next_c.short_sel = I_WDATA[BIT_SHORT];
                    next_c.fast_test = I_WDATA[BIT_FAST];
                    if (I_WDATA[BIT_REQERR]) begin
                        next_c.req_err = 1'b0;
                    end
                    if (I_WDATA[BIT_ROMERR]) begin
                        next_c.rom_err = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        // Results are read only after the done toggle has crossed, so the link side is idle and stable.
        if (done_edge) begin
            next_c.eng_busy = 1'b0;
            if (c.eng_auto) begin
                if (l.err || (c.auto_idx == 2'd0 && l.rd_byte != FORMAT_MARK)) begin
                    next_c.rom_err = 1'b1;
                    next_c.rom_busy = 1'b0;
                    next_c.auto_st = AU_DONE;
                end else begin
                    if (c.auto_idx == 2'd1) begin
                        next_c.subsys[7:0] = l.rd_byte;
                    end
                    if (c.auto_idx == 2'd2) begin
                        next_c.subsys[15:8] = l.rd_byte;
                    end
                    if (c.auto_idx == AUTO_LAST) begin
                        next_c.rom_busy = 1'b0;
                        next_c.auto_st = AU_DONE;
                    end else begin
                        next_c.auto_idx = c.auto_idx + 2'd1;
                        next_c.auto_st = AU_LAUNCH;
                    end
                end
            end else begin
                next_c.req_busy = 1'b0;
                if (l.err) begin
                    next_c.req_err = 1'b1;
                end else if (c.snap_rd) begin
                    next_c.xfer_data = l.rd_byte;
                end
            end
        end
        case (c.auto_st)
            AU_STRAP: begin
                next_c.strap_cnt = c.strap_cnt + 2'd1;
                if (c.strap_cnt == STRAP_WAIT) begin
                    next_c.present = !c.strap_s2;
                    next_c.pins_free = c.strap_s2;
                    next_c.rom_busy = !c.strap_s2;
                    next_c.auto_st = c.strap_s2 ? AU_DONE : AU_LAUNCH;
                end
            end
            AU_LAUNCH: begin
                if (!c.eng_busy) begin
                    next_c.snap_addr = EEPROM_ADDR;
                    next_c.snap_rd = 1'b1;
                    next_c.snap_short = 1'b0;
                    next_c.snap_idx = {6'd0, c.auto_idx};
                    next_c.eng_auto = 1'b1;
                    next_c.eng_busy = 1'b1;
                    next_c.req_tgl = !c.req_tgl;
                    next_c.auto_st = AU_WAIT;
                end
            end
            AU_DONE: begin
                if (c.pend && !c.eng_busy) begin
                    next_c.snap_addr = c.taddr[7:1];
                    next_c.snap_rd = c.taddr[BIT_DIR];
                    next_c.snap_short = c.short_sel;
                    next_c.snap_idx = c.byte_addr;
                    next_c.snap_data = c.xfer_data;
                    next_c.eng_auto = 1'b0;
                    next_c.eng_busy = 1'b1;
                    next_c.pend = 1'b0;
                    next_c.req_tgl = !c.req_tgl;
                end
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            c <= '0;
        end else begin
            c <= next_c;
        end
    end

    assign tick = l.div == 8'd0;
    assign advance = tick && !(l.ph == 2'd2 && !l.scl_s2);
    assign op = l.abort ? OP_STOP : op_of(l.step, c.snap_rd, c.snap_short);
    assign cur_byte = byte_of(l.step, c.snap_rd, c.snap_short, c.snap_addr, c.snap_idx, c.snap_data);
    assign shv = (l.bitn == 4'd0) ? cur_byte : l.shreg;

    always_comb begin
        next_l = l;
        next_l.req_s1 = c.req_tgl;
        next_l.req_s2 = l.req_s1;
        next_l.req_s3 = l.req_s2;
        next_l.fast_s1 = c.fast_test;
        next_l.fast_s2 = l.fast_s1;
        next_l.scl_s1 = I_SCL;
        next_l.scl_s2 = l.scl_s1;
        next_l.sda_s1 = I_SDA;
        next_l.sda_s2 = l.sda_s1;
        next_l.pin_o = 1'b0;
        next_l.div = tick ? (l.fast_s2 ? FAST_RELOAD : QUARTER_RELOAD) : l.div - 8'd1;
        if (!l.run) begin
            if (l.req_s2 != l.req_s3) begin
                next_l.run = 1'b1;
                next_l.step = 3'd0;
                next_l.bitn = 4'd0;
                next_l.ph = 2'd0;
                next_l.abort = 1'b0;
                next_l.err = 1'b0;
            end
        end else if (advance) begin
            next_l.ph = l.ph + 2'd1;
            case (op)
                OP_START: begin
                    case (l.ph)
                        2'd0: begin
                            next_l.sda_oe = 1'b0;
                            next_l.scl_oe = 1'b0;
                        end
                        2'd2: next_l.sda_oe = 1'b1;
                        2'd3: begin
                            next_l.scl_oe = 1'b1;
                            next_l.step = l.step + 3'd1;
                        end
                        default: begin
                        end
                    endcase
                end
                OP_STOP: begin
                    case (l.ph)
                        2'd0: begin
                            next_l.scl_oe = 1'b1;
                            next_l.sda_oe = 1'b1;
                        end
                        2'd1: next_l.scl_oe = 1'b0;
                        2'd2: next_l.sda_oe = 1'b0;
                        default: begin
                            next_l.run = 1'b0;
                            next_l.done_tgl = !l.done_tgl;
                        end
                    endcase
                end
                default: begin
                    case (l.ph)
                        2'd0: begin
                            next_l.scl_oe = 1'b1;
                            next_l.sda_oe = 1'b0;
                            if (op == OP_WRITE && l.bitn != ACK_SLOT) begin
                                next_l.shreg = shv;
                                next_l.sda_oe = !shv[7];
                            end
                        end
                        2'd1: next_l.scl_oe = 1'b0;
                        2'd2: begin
                            if (l.bitn == ACK_SLOT) begin
                                if (op == OP_WRITE && l.sda_s2) begin
                                    next_l.err = 1'b1;
                                end
                            end else if (op == OP_WRITE) begin
                                next_l.shreg = {l.shreg[6:0], 1'b0};
                            end else begin
                                next_l.shreg = {l.shreg[6:0], l.sda_s2};
                            end
                        end
                        default: begin
                            next_l.scl_oe = 1'b1;
                            if (l.bitn == ACK_SLOT) begin
                                next_l.bitn = 4'd0;
                                next_l.step = l.step + 3'd1;
                                next_l.abort = l.err;
                                if (op == OP_READ) begin
                                    next_l.rd_byte = l.shreg;
                                end
                            end else begin
                                next_l.bitn = l.bitn + 4'd1;
                            end
                        end
                    endcase
                end
            endcase
        end
    end

    always_ff @(posedge I_LINK_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            l <= '0;
        end else begin
            l <= next_l;
        end
    end

    assign O_RDATA = c.rdata;
    assign O_SUBSYS_ID = c.subsys;
    assign O_SHARED_PINS_FREE = c.pins_free;
    assign O_SCL_O = l.pin_o;
    assign O_SDA_O = l.pin_o;
    assign O_SCL_OE = l.scl_oe;
    assign O_SDA_OE = l.sda_oe;

    AST_RSVD_ZERO:
    assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
        (I_RD && I_ADDR == OFS_CTRL) |=> (O_RDATA[BIT_RSVD] == 1'b0 && O_RDATA[BIT_REQ] == $past(c.req_busy)))
        else $error("Control read shows a wrong reserved or busy bit.");

    AST_LAUNCH_BUSY:
    assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
        (I_WR && I_ADDR == OFS_TADDR && !c.req_busy) |=> c.req_busy)
        else $error("Target address write did not raise the busy flag.");

    AST_BUSY_HOLD:
    assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
        (c.req_busy && !(done_edge && !c.eng_auto)) |=> c.req_busy)
        else $error("Busy flag dropped before the access ended.");

    AST_DONE_CLEAR:
    assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
        (c.req_busy && done_edge && !c.eng_auto && !(I_WR && I_ADDR == OFS_TADDR)) |=> !c.req_busy)
        else $error("Busy flag stayed set after the access ended.");

    AST_ROM_BUSY_END:
    assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
        $fell(c.rom_busy) |-> (c.auto_st == AU_DONE && !c.eng_busy))
        else $error("Load busy fell while the auto-load was still running.");

    AST_PINS_FREE:
    assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
        (c.auto_st != AU_STRAP) |-> (O_SHARED_PINS_FREE == !c.present))
        else $error("Shared pin release disagrees with the bus present flag.");

    AST_REQERR_STICKY:
    assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
        (c.req_err && !(I_WR && I_ADDR == OFS_CTRL && I_WDATA[BIT_REQERR])) |=> c.req_err)
        else $error("Request fault cleared without a write of one.");

    AST_ROMERR_STICKY:
    assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
        (c.rom_err && !(I_WR && I_ADDR == OFS_CTRL && I_WDATA[BIT_ROMERR])) |=> c.rom_err)
        else $error("Autoload fault cleared without a write of one.");

    AST_QUARTER:
    assert property (@(posedge I_LINK_CLK) disable iff (!I_RST_B)
        (tick && !l.fast_s2) |=> (l.div == QUARTER_RELOAD) ##1 (l.div == QUARTER_RELOAD - 8'd1))
        else $error("Bus clock quarter period does not match the normal rate.");

    AST_SHORT_SKIP:
    assert property (@(posedge I_LINK_CLK) disable iff (!I_RST_B)
        (l.run && !l.abort && c.snap_short && l.step == 3'd2) |-> (c.snap_rd ? op == OP_READ : cur_byte == c.snap_data))
        else $error("Short protocol still sends the index byte.");

endmodule

`default_nettype wire

/* File: sbc_target.sv */
// Behavioural two-wire bus target holding a byte image, answering at two addresses.
`timescale 1ns/1ps
`default_nettype none

module sbc_target #(
    parameter logic [6:0] ADDR_A = 7'h50,
    parameter logic [6:0] ADDR_B = 7'h21
) (
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_refuse,
    input wire logic i_hold,
    output logic o_sda_oe,
    output logic o_scl_oe
);
    logic [7:0] mem [256];
    logic [7:0] sh = 8'h00;
    logic [7:0] tx = 8'h00;
    logic [7:0] ptr = 8'h00;
    logic [7:0] last_rx = 8'h00;
    int bits = 0;
    int rx_cnt = 0;
    int done_wr = 0;
    logic first = 1'b0;
    logic sel = 1'b0;
    logic sending = 1'b0;

    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i * 37 + 11);
        end
        mem[0] = 8'h5A;
        o_sda_oe = 1'b0;
        o_scl_oe = 1'b0;
    end

    // A falling data line with the clock high opens a frame, a rising one closes it.
    always @(negedge i_sda) begin
        if (i_scl === 1'b1) begin
            bits = 0;
            first = 1'b1;
            sending = 1'b0;
        end
    end

    always @(posedge i_sda) begin
        if (i_scl === 1'b1) begin
            done_wr = rx_cnt;
            rx_cnt = 0;
            sel = 1'b0;
            sending = 1'b0;
        end
    end

    always @(posedge i_scl) begin
        if (bits < 8) begin
            sh = {sh[6:0], i_sda};
            bits = bits + 1;
        end else begin
            if (i_sda === 1'b1) begin
                sending = 1'b0;
            end
            bits = 0;
        end
    end

    // The first byte after a start picks the target and the direction.
    always @(negedge i_scl) begin
        if (bits == 8 && !sending) begin
            if (first) begin
                sel = (sh[7:1] == ADDR_A || sh[7:1] == ADDR_B) && !i_refuse;
                sending = sel && sh[0];
                tx = mem[ptr];
                if (sending) begin
                    ptr = ptr + 1;
                end
            end else if (sel) begin
                rx_cnt = rx_cnt + 1;
                last_rx = sh;
                if (rx_cnt == 1) begin
                    ptr = sh;
                end else begin
                    mem[ptr] = sh;
                    ptr = ptr + 1;
                end
            end
            first = 1'b0;
            o_sda_oe = sel;
            if (i_hold) begin
                o_scl_oe = 1'b1;
                o_scl_oe <= #3000 1'b0;
            end
        end else if (sending && bits < 8) begin
            o_sda_oe = ~tx[7 - bits];
        end else begin
            o_sda_oe = 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: test_serial_bus_control_status.sv */
// Self-checking bench for the serial bus control and status block.
`timescale 1ns/1ps
`default_nettype none

module test_serial_bus_control_status;
    import sbc_pkg::*;
    logic clk, lclk, rst_b, wr, rd, strap, refuse, hold;
    logic [7:0] addr, wdata, rdata, v, p;
    logic scl_oe, sda_oe, t_scl_oe, t_sda_oe, pins_free;
    logic [15:0] subsys;
    logic [31:0] r;
    logic [7:0] mir [256];
    int n_fail, compares, seed, n_scl;
    longint t_first, t_last, avg;
    wire logic scl = ~(scl_oe | t_scl_oe);
    wire logic sda = ~(sda_oe | t_sda_oe);

    sbc_ctrl sbc_ctrl_i (.I_CORE_CLK(clk), .I_RST_B(rst_b), .I_LINK_CLK(lclk), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_LATCH_STRAP(strap), .I_SCL(scl),
        .O_SCL_O(), .O_SCL_OE(scl_oe), .I_SDA(sda), .O_SDA_O(), .O_SDA_OE(sda_oe),
        .O_SUBSYS_ID(subsys), .O_SHARED_PINS_FREE(pins_free));

    sbc_target sbc_target_i (.i_scl(scl), .i_sda(sda), .i_refuse(refuse), .i_hold(hold),
        .o_sda_oe(t_sda_oe), .o_scl_oe(t_scl_oe));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        lclk = 1'b0;
        #7;
        forever #24 lclk = ~lclk;
    end

    always @(posedge scl_oe) begin
        if (n_scl == 0) begin
            t_first = $time;
        end
        t_last = $time;
        n_scl++;
    end

    function automatic logic [7:0] img(input int i);
        return (i == 0) ? 8'h5A : 8'(i * 37 + 11);
    endfunction

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic ctrl_is(input logic [7:0] e);
        rd_reg(OFS_CTRL, v);
        chk("ctrl", e, v);
    endtask

    task automatic wait_clear(input int b);
        int n;
        n = 0;
        v = 8'hFF;
        while (v[b] !== 1'b0 && n < 10000) begin
            rd_reg(OFS_CTRL, v);
            n++;
        end
        chk("poll", 0, 16'(v[b]));
    endtask

    task automatic do_reset(input logic s);
        rst_b <= 1'b0;
        strap <= s;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge clk);
    endtask

    task automatic xfer(input logic [6:0] a, input logic dir, input logic [7:0] idx, input logic [7:0] dat,
        input logic sh);
        wr_reg(OFS_DATA, dat);
        wr_reg(OFS_INDEX, idx);
        wr_reg(OFS_TADDR, {a, dir});
        rd_reg(OFS_CTRL, v);
        chk("busy", 1, 16'(v[BIT_REQ]));
        wait_clear(BIT_REQ);
        chk("bytes", sh ? 16'(!dir) : 16'(2 - dir), 16'(sbc_target_i.done_wr));
        if (dir == 1'b0) begin
            chk("rx", dat, sbc_target_i.last_rx);
            if (sh) begin
                p = dat;
            end else begin
                mir[idx] = dat;
                p = idx + 1;
            end
        end else begin
            if (!sh) begin
                p = idx;
            end
            rd_reg(OFS_DATA, v);
            chk("rdata", mir[p], v);
            p = p + 1;
        end
    endtask

    task automatic tally_and_finish();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        #(100 * 90000);
        n_fail++;
        $display("FAIL watchdog expected done seen running");
        tally_and_finish();
    end

    initial begin
        rst_b = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        strap = 1'b1;
        refuse = 1'b0;
        hold = 1'b0;
        n_fail = 0;
        compares = 0;
        n_scl = 0;
        seed = 84651;
        p = 8'h00;
        for (int i = 0; i < 256; i++) begin
            mir[i] = img(i);
        end
        do_reset(1'b1);
        ctrl_is(8'h00);
        chk("pins_free", 1, 16'(pins_free));
        do_reset(1'b0);
        ctrl_is(8'h18);
        wait_clear(BIT_ROM);
        chk("subsys", {img(2), img(1)}, subsys);
        chk("pins_used", 0, 16'(pins_free));
        ctrl_is(8'h08);
        wr_reg(OFS_CTRL, 8'hFF);
        ctrl_is(8'h8C);
        rd_reg(8'hB4, v);
        chk("unmapped", 0, v);
        wr_reg(OFS_CTRL, 8'h00);
        n_scl = 0;
        xfer(7'h50, 1'b0, 8'h10, 8'hC3, 1'b0);
        avg = (t_last - t_first) / (n_scl - 1);
        chk("scl_norm", 1, 16'(avg > 9000 && avg < 11000));
        wr_reg(OFS_CTRL, 8'h04);
        n_scl = 0;
        xfer(7'h21, 1'b0, 8'h11, 8'h3C, 1'b0);
        avg = (t_last - t_first) / (n_scl - 1);
        chk("scl_fast", 1, 16'(avg > 0 && avg < 2544));
        for (int k = 0; k < 16; k++) begin
            r = $random(seed);
            hold = r[3];
            wr_reg(OFS_CTRL, {r[0], 7'h04});
            xfer(r[1] ? 7'h50 : 7'h21, r[2], r[15:8], r[23:16], r[0]);
            ctrl_is({r[0], 7'h0C});
        end
        hold = 1'b0;
        refuse = 1'b1;
        wr_reg(OFS_CTRL, 8'h04);
        wr_reg(OFS_TADDR, 8'hA0);
        wait_clear(BIT_REQ);
        ctrl_is(8'h0E);
        wr_reg(OFS_CTRL, 8'h04);
        ctrl_is(8'h0E);
        wr_reg(OFS_CTRL, 8'h06);
        ctrl_is(8'h0C);
        for (int k = 0; k < 2; k++) begin
            refuse = k[0];
            sbc_target_i.mem[0] = k[0] ? 8'h5A : 8'hA6;
            do_reset(1'b0);
            wait_clear(BIT_ROM);
            ctrl_is(8'h09);
            wr_reg(OFS_CTRL, 8'h01);
            ctrl_is(8'h08);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
